// ==== verilog/line_ctl_defines.vh ====
// Constants for the line activation command decoder
`ifndef LINE_CTL_DEFINES_VH
`define LINE_CTL_DEFINES_VH
// Command codes (8 bits, chosen)
`define CMD_POWER_ON 8'h20
`define CMD_POWER_OFF 8'h00
`define CMD_ACT_REQ 8'h03
`define CMD_DEACT_REQ 8'h0f
`define CMD_FORCED_TEST 8'h01
`define CMD_MONITOR 8'h1b
`define CMD_NET_ADAPT 8'h04
`define CMD_NET_FIXED 8'h14
`define CMD_TERM_MASTER 8'h08
`define CMD_TERM_SLAVE 8'h09
`define CMD_D_CHANNEL_REQUEST_CMD 8'h0a
`define CMD_FMT_BASE 8'h40
`define CMD_RATE_BASE 8'h90
`define CMD_NOP 8'hff
// Status codes returned on the serial port
`define ST_NONE 8'h00
`define ST_EOM 8'h06
`define ST_COLLISION 8'h07
`define ST_ACTIVATED 8'h0c
`define ST_ERROR 8'h0e
`define ST_PENDING 8'h08
`define ST_DEACTIVATED 8'h0f
// Mode field codes
`define MODE_NET_ADAPT 2'h0
`define MODE_NET_FIXED 2'h1
`define MODE_TERM_MASTER 2'h2
`define MODE_TERM_SLAVE 2'h3
// Event vector bit positions, lower index reported first
`define EV_PENDING 0
`define EV_ACTIVATED 1
`define EV_DEACTIVATED 2
`define EV_ERROR 3
`define EV_COLLISION 4
`define EV_EOM 5
`define EV_COUNT 6
`endif

// ==== verilog/line_activation_command_control.v ====
// Control instruction decoder for a basic-access line transceiver
//
// Functional notes
// - Power-on enables analog, oscillator, resets deactivated
// - Power-on inhibits line signal detect
// - Power-off goes low power at once
// - Deactivation request runs deactivation sequence
// - Forced test frame: network, activated, sends frame2
// - Frame 3 during test: pending, no data
// - Monitor mode activates on frame 3, master
// - Network modes: interface slave to outside clocks
// - Network fixed mode disables receive phase loop
// - Terminal master drives clocks, D access enabled
// - Terminal slave: D transparent, requests ignored
// - Format selection applies matching default rate
// - Rate commands change current format's rate
// - Echo mismatch during packet raises collision, in terminal master mode only
// - Successful activation raises activated event
// - Frame alignment loss raises error event
// - Pending event signals line trying to activate
module line_activation_command_control (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Serial control port
   input wire ctl_clk,
   input wire ctl_sel_n,
   input wire ctl_din,
   output reg ctl_dout,
   // Line receiver status, from the analog side
   input wire rx_frame3,
   input wire rx_frame4,
   input wire rx_frame_align,
   input wire rx_line_signal,
   // D channel status, same clock domain
   input wire d_packet_active,
   input wire d_echo_bit,
   input wire d_tx_bit,
   input wire d_echo_strobe,
   input wire d_packet_done,
   // Power and line control
   output reg analog_enable,
   output reg osc_enable,
   output reg line_signal_detect,
   output reg send_frame2,
   output reg send_frame4,
   output reg data_tx_enable,
   // Mode outputs
   output reg iface_master,
   output reg receive_phase_loop_en,
   output reg d_access_enable,
   output reg d_transparent,
   output reg d_access_strobe_sclk,
   output reg d_channel_request,
   output reg monitor_active,
   output reg [1:0] iface_format,
   output reg [1:0] bit_rate
);
`include "line_ctl_defines.vh"

   localparam [3:0] ST_OFF = 4'h1;
   localparam [3:0] ST_DEACT = 4'h2;
   localparam [3:0] ST_PEND = 4'h4;
   localparam [3:0] ST_ACTIVE = 4'h8;

   // Synchronisers for pins from other domains
   reg [1:0] clk_s_r, sel_s_r, din_s_r, f3_s_r, f4_s_r, al_s_r, ls_s_r;
   reg clk_d_r;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         clk_s_r <= 2'h0;
         sel_s_r <= 2'h3;
         din_s_r <= 2'h0;
         f3_s_r <= 2'h0;
         f4_s_r <= 2'h0;
         al_s_r <= 2'h0;
         ls_s_r <= 2'h0;
         clk_d_r <= 1'b0;
      end else begin
         clk_s_r <= {clk_s_r[0], ctl_clk};
         sel_s_r <= {sel_s_r[0], ctl_sel_n};
         din_s_r <= {din_s_r[0], ctl_din};
         f3_s_r <= {f3_s_r[0], rx_frame3};
         f4_s_r <= {f4_s_r[0], rx_frame4};
         al_s_r <= {al_s_r[0], rx_frame_align};
         ls_s_r <= {ls_s_r[0], rx_line_signal};
         clk_d_r <= clk_s_r[1];
      end
   end
   wire sclk_rise = clk_s_r[1] & ~clk_d_r;
   wire sclk_fall = ~clk_s_r[1] & clk_d_r;
   wire selected = ~sel_s_r[1];
   wire frame3 = f3_s_r[1];
   wire frame4 = f4_s_r[1];
   wire aligned = al_s_r[1];

   // Serial shift: command in on rising edge, status out on falling edge
   reg [7:0] shift_in_r, shift_out_r;
   reg [2:0] bit_cnt_r;
   reg cmd_valid_r, sel_d_r;
   reg [7:0] cmd_r;
   wire sel_start = selected & ~sel_d_r;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_in_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         cmd_valid_r <= 1'b0;
         cmd_r <= 8'h00;
         sel_d_r <= 1'b0;
      end else begin
         sel_d_r <= selected;
         cmd_valid_r <= 1'b0;
         if (!selected) begin
            bit_cnt_r <= 3'h0;
         end else if (sclk_rise) begin
            shift_in_r <= {shift_in_r[6:0], din_s_r[1]};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
               cmd_r <= {shift_in_r[6:0], din_s_r[1]};
               cmd_valid_r <= 1'b1;
            end
         end
      end
   end

   // Event flags: set wins over clear
   reg [`EV_COUNT-1:0] ev_r, ev_set;
   reg [`EV_COUNT-1:0] ev_clr;
   reg [7:0] status_code;
   integer i;
   always @* begin
      status_code = `ST_NONE;
      ev_clr = {`EV_COUNT{1'b0}};
      for (i = `EV_COUNT - 1; i >= 0; i = i - 1) begin
         if (ev_r[i]) begin
            ev_clr = {`EV_COUNT{1'b0}};
            ev_clr[i] = 1'b1;
            case (i)
               `EV_PENDING: status_code = `ST_PENDING;
               `EV_ACTIVATED: status_code = `ST_ACTIVATED;
               `EV_DEACTIVATED: status_code = `ST_DEACTIVATED;
               `EV_ERROR: status_code = `ST_ERROR;
               `EV_COLLISION: status_code = `ST_COLLISION;
               default: status_code = `ST_EOM;
            endcase
         end
      end
   end

   // Status byte loaded at select, shifted out on falling edges
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_out_r <= 8'h00;
         ctl_dout <= 1'b0;
      end else if (sel_start) begin
         shift_out_r <= {status_code[6:0], 1'b0};
         ctl_dout <= status_code[7];
      end else if (selected && sclk_fall) begin
         ctl_dout <= shift_out_r[7];
         shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset)
         ev_r <= {`EV_COUNT{1'b0}};
      else
         ev_r <= (ev_r & ~(sel_start ? ev_clr : {`EV_COUNT{1'b0}})) | ev_set;
   end

   // Activation state and configuration
   reg [3:0] state_r, state_nxt;
   reg [1:0] mode_r;
   reg forced_r, monitor_r, act_req_r, aligned_d_r;
   wire is_net = (mode_r == `MODE_NET_ADAPT) || (mode_r == `MODE_NET_FIXED);
   // Low two bits carry the choice; masking keeps both sides of the compare at 8 bits
   wire cmd_fmt = cmd_valid_r && ((cmd_r & 8'hfc) == `CMD_FMT_BASE);
   wire cmd_rate = cmd_valid_r && ((cmd_r & 8'hfc) == `CMD_RATE_BASE);
   wire cmd_is = cmd_valid_r;
   wire c_on = cmd_is && cmd_r == `CMD_POWER_ON;
   wire c_off = cmd_is && cmd_r == `CMD_POWER_OFF;
   wire c_ar = cmd_is && cmd_r == `CMD_ACT_REQ;
   wire c_dr = cmd_is && cmd_r == `CMD_DEACT_REQ;
   wire c_fi = cmd_is && cmd_r == `CMD_FORCED_TEST;
   wire c_mm = cmd_is && cmd_r == `CMD_MONITOR;
   // Frame the far end should be sending us to complete activation
   wire far_ok = (is_net || monitor_r) ? frame3 : frame4;

   // Next activation state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (c_on)
               state_nxt = ST_DEACT;
         end
         ST_DEACT: begin
            // A refused monitor command must not start activation either
            if (c_ar || (c_mm && mode_r == `MODE_TERM_MASTER))
               state_nxt = ST_PEND;
         end
         ST_PEND: begin
            if (far_ok && aligned)
               state_nxt = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            if (c_ar && forced_r)
               state_nxt = ST_ACTIVE;
         end
         default: state_nxt = ST_DEACT;
      endcase
      if (c_dr && state_r != ST_OFF)
         state_nxt = ST_DEACT;
      if (c_off)
         state_nxt = ST_OFF;
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= ST_OFF;
         mode_r <= `MODE_NET_ADAPT;
         forced_r <= 1'b0;
         monitor_r <= 1'b0;
         act_req_r <= 1'b0;
         aligned_d_r <= 1'b0;
         iface_format <= 2'h0;
         bit_rate <= 2'h0;
         d_channel_request <= 1'b0;
      end else begin
         state_r <= state_nxt;
         aligned_d_r <= aligned;
         if (cmd_valid_r) begin
            case (cmd_r)
               `CMD_NET_ADAPT: mode_r <= `MODE_NET_ADAPT;
               `CMD_NET_FIXED: mode_r <= `MODE_NET_FIXED;
               `CMD_TERM_MASTER: mode_r <= `MODE_TERM_MASTER;
               `CMD_TERM_SLAVE: mode_r <= `MODE_TERM_SLAVE;
               default: mode_r <= mode_r;
            endcase
         end
         if (cmd_fmt) begin
            iface_format <= cmd_r[1:0];
            bit_rate <= cmd_r[1:0];
         end
         if (cmd_rate)
            bit_rate <= cmd_r[1:0];
         d_channel_request <= cmd_is && cmd_r == `CMD_D_CHANNEL_REQUEST_CMD && mode_r == `MODE_TERM_MASTER;
         if (c_fi && is_net && state_r == ST_ACTIVE)
            forced_r <= 1'b1;
         else if (c_ar || state_nxt != ST_ACTIVE)
            forced_r <= 1'b0;
         if (c_mm && mode_r == `MODE_TERM_MASTER)
            monitor_r <= 1'b1;
         else if (c_off || c_dr || c_on)
            monitor_r <= 1'b0;
         if (c_ar)
            act_req_r <= 1'b1;
         else if (state_nxt != ST_PEND && state_nxt != ST_ACTIVE)
            act_req_r <= 1'b0;
      end
   end

   // Event sources
   always @* begin
      ev_set = {`EV_COUNT{1'b0}};
      ev_set[`EV_PENDING] = (state_r == ST_DEACT && (frame3 || frame4) && !is_net) ||
                            (state_r == ST_DEACT && frame3 && is_net);
      if (c_fi && is_net && state_r == ST_ACTIVE && frame3)
         ev_set[`EV_PENDING] = 1'b1;
      ev_set[`EV_ACTIVATED] = state_r == ST_PEND && state_nxt == ST_ACTIVE && (act_req_r || monitor_r);
      ev_set[`EV_DEACTIVATED] = state_r == ST_ACTIVE && state_nxt == ST_DEACT;
      ev_set[`EV_ERROR] = state_r == ST_ACTIVE && aligned_d_r && !aligned;
      ev_set[`EV_COLLISION] = d_packet_active && d_echo_strobe && (d_echo_bit != d_tx_bit) &&
                              mode_r == `MODE_TERM_MASTER;
      ev_set[`EV_EOM] = d_packet_done && mode_r == `MODE_TERM_MASTER;
   end

   // Registered outputs decoded from state and mode
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         analog_enable <= 1'b0;
         osc_enable <= 1'b0;
         line_signal_detect <= 1'b0;
         send_frame2 <= 1'b0;
         send_frame4 <= 1'b0;
         data_tx_enable <= 1'b0;
         iface_master <= 1'b0;
         receive_phase_loop_en <= 1'b1;
         d_access_enable <= 1'b0;
         d_transparent <= 1'b0;
         d_access_strobe_sclk <= 1'b0;
         monitor_active <= 1'b0;
      end else begin
         analog_enable <= state_r != ST_OFF;
         osc_enable <= state_r != ST_OFF;
         line_signal_detect <= state_r == ST_OFF && ls_s_r[1];
         send_frame2 <= is_net && ((state_r == ST_PEND) || (state_r == ST_ACTIVE && forced_r));
         send_frame4 <= is_net && state_r == ST_ACTIVE && !forced_r;
         data_tx_enable <= state_r == ST_ACTIVE && !forced_r;
         iface_master <= mode_r == `MODE_TERM_MASTER;
         receive_phase_loop_en <= mode_r != `MODE_NET_FIXED;
         d_access_enable <= mode_r == `MODE_TERM_MASTER;
         d_transparent <= mode_r == `MODE_TERM_SLAVE;
         d_access_strobe_sclk <= mode_r == `MODE_TERM_SLAVE;
         // Gated by mode so a later mode change drops monitor with master
         monitor_active <= monitor_r && mode_r == `MODE_TERM_MASTER;
      end
   end
endmodule // line_activation_command_control

// ==== tb/line_ctl_sva.sv ====
// Assertion checker for the line activation command decoder
module line_ctl_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Power and line
   input wire logic rx_line_signal,
   input wire logic analog_enable,
   input wire logic osc_enable,
   input wire logic line_signal_detect,
   input wire logic send_frame2,
   input wire logic send_frame4,
   input wire logic data_tx_enable,
   // Modes
   input wire logic iface_master,
   input wire logic receive_phase_loop_en,
   input wire logic d_access_enable,
   input wire logic d_transparent,
   input wire logic d_access_strobe_sclk,
   input wire logic d_channel_request,
   input wire logic monitor_active,
   input wire logic [1:0] iface_format,
   input wire logic [1:0] bit_rate
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_osc; analog_enable == osc_enable; endproperty
   a_osc: assert property (p_osc) else $error("oscillator and analog enables differ");
   property p_lsd_quiet; analog_enable |-> !line_signal_detect; endproperty
   a_lsd_quiet: assert property (p_lsd_quiet) else $error("wake-up shown while powered");
   // Six cycles cover the input synchroniser and the output register
   property p_lsd_wake; (!analog_enable && rx_line_signal)[*6] |-> line_signal_detect; endproperty
   a_lsd_wake: assert property (p_lsd_wake) else $error("no wake-up while powered off");
   property p_master; iface_master |-> !d_transparent && !d_access_strobe_sclk; endproperty
   a_master: assert property (p_master) else $error("master with slave D features");
   property p_slave; d_transparent |-> d_access_strobe_sclk && !d_access_enable && !iface_master; endproperty
   a_slave: assert property (p_slave) else $error("slave D path inconsistent");
   property p_req; d_channel_request |-> (d_access_enable && !d_transparent) ##1 !d_channel_request; endproperty
   a_req: assert property (p_req) else $error("bad D request pulse");
   property p_forced; send_frame2 |-> !send_frame4 && !data_tx_enable && !iface_master; endproperty
   a_forced: assert property (p_forced) else $error("test frame with data or frame 4");
   property p_fmt; $changed(iface_format) |-> bit_rate == iface_format; endproperty
   a_fmt: assert property (p_fmt) else $error("format without its default rate");
   property p_pll; !receive_phase_loop_en |-> !iface_master && !d_transparent; endproperty
   a_pll: assert property (p_pll) else $error("phase loop off outside fixed mode");
   property p_mon; monitor_active |-> iface_master; endproperty
   a_mon: assert property (p_mon) else $error("monitor without master");
endmodule // line_ctl_sva

bind line_activation_command_control line_ctl_sva i_line_ctl_sva (.clock, .reset, .rx_line_signal,
   .analog_enable, .osc_enable, .line_signal_detect, .send_frame2, .send_frame4, .data_tx_enable,
   .iface_master, .receive_phase_loop_en, .d_access_enable, .d_transparent, .d_access_strobe_sclk,
   .d_channel_request, .monitor_active, .iface_format, .bit_rate);

// ==== tb/ctl_master.sv ====
// Controller model driving the serial command port
module ctl_master (
   // Clock
   input wire logic clock,
   // Serial port
   output logic ctl_clk,
   output logic ctl_sel_n,
   output logic ctl_din,
   input wire logic ctl_dout
);
   timeunit 1ns;
   timeprecision 100ps;
   // Port clock stands still low outside frames
   initial begin
      ctl_clk = 1'h0;
      ctl_sel_n = 1'h1;
      ctl_din = 1'h0;
   end
   // Half port period of 8 system clocks, 40 ns
   task automatic hold();
      repeat (8) @(posedge clock);
   endtask
   // One byte each way, MSB first, status taken at each rise
   task automatic xfer(input logic [7:0] cmd, output logic [7:0] st);
      ctl_sel_n <= 1'h0;
      for (int i = 7; i >= 0; i--) begin
         ctl_din <= cmd[i];
         hold();
         st[i] = ctl_dout;
         ctl_clk <= 1'h1;
         hold();
         ctl_clk <= 1'h0;
      end
      hold();
      ctl_sel_n <= 1'h1;
      ctl_din <= ~ctl_din; // Released line does not keep its value
   endtask
endmodule // ctl_master

// ==== tb/line_activation_command_control_tb.sv ====
// Self-checking bench for the line activation command decoder
`include "line_ctl_defines.vh"
module line_activation_command_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'h0;
   logic reset = 1'h1;
   logic ctl_clk, ctl_sel_n, ctl_din, ctl_dout, send_frame2, send_frame4, data_tx_enable;
   logic rx_frame3 = 1'h0, rx_frame4 = 1'h0, rx_frame_align = 1'h0, rx_line_signal = 1'h1;
   logic d_packet_active = 1'h0, d_echo_bit = 1'h0, d_tx_bit = 1'h0, d_echo_strobe = 1'h0, d_packet_done = 1'h0;
   logic analog_enable, osc_enable, line_signal_detect, iface_master, receive_phase_loop_en;
   logic d_access_enable, d_transparent, d_access_strobe_sclk, d_channel_request, monitor_active;
   logic [1:0] iface_format, bit_rate;
   logic [7:0] st;
   logic [31:0] seed = 32'h9;
   logic [7:0] mode_cmd [4] = '{`CMD_NET_ADAPT, `CMD_NET_FIXED, `CMD_TERM_MASTER, `CMD_TERM_SLAVE};
   int pw = 0, mode = 0, fmt = 0, rate = 0, miscompares = 0, samples_checked = 0, cycles = 0, d_channel_request_cmd_pulses = 0;
   line_activation_command_control i_line_activation_command_control (.clock, .reset, .ctl_clk,
      .ctl_sel_n, .ctl_din, .ctl_dout, .rx_frame3, .rx_frame4, .rx_frame_align, .rx_line_signal,
      .d_packet_active, .d_echo_bit, .d_tx_bit, .d_echo_strobe, .d_packet_done, .analog_enable,
      .osc_enable, .line_signal_detect, .send_frame2, .send_frame4, .data_tx_enable, .iface_master,
      .receive_phase_loop_en, .d_access_enable, .d_transparent, .d_access_strobe_sclk,
      .d_channel_request, .monitor_active, .iface_format, .bit_rate);
   ctl_master i_ctl_master (.clock, .ctl_clk, .ctl_sel_n, .ctl_din, .ctl_dout);
   always #2.5 clock = ~clock;
   // Count request pulses; the cycle ceiling cuts a hang short
   always @(posedge clock) begin
      cycles++;
      if (d_channel_request === 1'h1) d_channel_request_cmd_pulses++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Static outputs against the reference state
   task automatic outs(input string what);
      chk(what, {4'h0, pw[0], pw[0], (pw == 0) && rx_line_signal, mode == 2, mode != 1, mode == 2, mode == 3,
         mode == 3, fmt[1:0], rate[1:0]}, {4'h0, analog_enable, osc_enable, line_signal_detect, iface_master,
         receive_phase_loop_en, d_access_enable, d_transparent, d_access_strobe_sclk, iface_format, bit_rate});
   endtask
   task automatic cmd(input logic [7:0] c);
      i_ctl_master.xfer(c, st);
      repeat (12) @(posedge clock);
   endtask
   // Poll status until the wanted code; other events are skipped
   task automatic expect_ev(input logic [7:0] code);
      int n;
      for (n = 0; n < 6; n++) begin
         cmd(`CMD_NOP);
         if (st === code || st === `ST_NONE) break;
      end
      chk("status", {8'h0, code}, {8'h0, st});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'h0;
      // Line detect needs the two-stage synchroniser and its output register
      repeat (6) @(posedge clock);
      outs("reset");
      cmd(`CMD_POWER_ON);
      pw = 1;
      outs("power on");
      // Rate is always chosen after its format, and the next format overrides it
      for (int f = 0; f < 4; f++) begin
         seed = xs(seed);
         cmd(`CMD_FMT_BASE + f[7:0]);
         fmt = f;
         rate = f;
         outs("format");
         cmd(`CMD_RATE_BASE + {6'h0, seed[1:0]});
         rate = seed[1:0];
         outs("rate");
      end
      for (int m = 0; m < 4; m++) begin
         cmd(mode_cmd[m]);
         mode = m;
         outs("mode");
      end
      cmd(`CMD_D_CHANNEL_REQUEST_CMD);
      chk("req slave", 16'h0, 16'(d_channel_request_cmd_pulses));
      cmd(`CMD_TERM_MASTER);
      mode = 2;
      cmd(`CMD_D_CHANNEL_REQUEST_CMD);
      chk("req master", 16'h1, 16'(d_channel_request_cmd_pulses));
      // Echo differs from the sent D bit in mid-packet
      seed = xs(seed);
      d_packet_active <= 1'h1;
      d_tx_bit <= seed[0];
      d_echo_bit <= ~seed[0];
      @(posedge clock);
      d_echo_strobe <= 1'h1;
      @(posedge clock);
      d_echo_strobe <= 1'h0;
      d_packet_active <= 1'h0;
      d_packet_done <= 1'h1;
      @(posedge clock);
      d_packet_done <= 1'h0;
      expect_ev(`ST_COLLISION);
      expect_ev(`ST_EOM);
      cmd(`CMD_NET_ADAPT);
      mode = 0;
      expect_ev(`ST_NONE);
      // No settling timer in the design, so the wait after power-on is shortened
      cmd(`CMD_ACT_REQ);
      rx_frame3 <= 1'h1;
      rx_frame_align <= 1'h1;
      cmd(`CMD_NOP);
      expect_ev(`ST_ACTIVATED);
      chk("frames", 16'h3, {13'h0, send_frame2, send_frame4, data_tx_enable});
      cmd(`CMD_FORCED_TEST);
      chk("frames test", 16'h4, {13'h0, send_frame2, send_frame4, data_tx_enable});
      expect_ev(`ST_PENDING);
      cmd(`CMD_ACT_REQ);
      chk("frames back", 16'h3, {13'h0, send_frame2, send_frame4, data_tx_enable});
      rx_frame_align <= 1'h0;
      cmd(`CMD_NOP);
      expect_ev(`ST_ERROR);
      cmd(`CMD_DEACT_REQ);
      rx_frame3 <= 1'h0;
      expect_ev(`ST_DEACTIVATED);
      expect_ev(`ST_NONE);
      cmd(`CMD_POWER_OFF);
      pw = 0;
      outs("power off");
      rx_line_signal <= 1'h0;
      cmd(`CMD_NOP);
      outs("no line");
      cmd(`CMD_POWER_ON);
      cmd(`CMD_MONITOR);
      chk("monitor refused", 16'h0, {15'h0, monitor_active});
      cmd(`CMD_TERM_MASTER);
      cmd(`CMD_MONITOR);
      chk("monitor", 16'h3, {14'h0, monitor_active, iface_master});
      end_sim();
   end
endmodule // line_activation_command_control_tb
